/* rtl/cfg_port_pkg.sv */
package cfg_port_pkg;
   // serial word layout
   localparam int WORD_BITS    = 16;
   localparam int CNT_W        = 5;
   localparam int RW_POS       = 15;
   localparam int ADDR_HI      = 14;
   localparam int ADDR_LO      = 8;
   localparam int DATA_HI      = 7;
   localparam int DATA_LO      = 0;
   localparam logic [4:0] LAST_BIT  = 5'h10;
   localparam logic [4:0] READ_FROM = 5'h08;
   // register offsets
   localparam logic [6:0] SOFT_RESET_ADDR   = 7'h00;
   localparam logic [6:0] POWER_FMT_ADDR    = 7'h01;
   localparam logic [6:0] OUT_DRIVE_ADDR    = 7'h02;
   // field positions
   localparam int SOFT_RESET_BIT  = 7;
   localparam int DCS_OFF_BIT     = 7;
   localparam int SCRAMBLE_BIT    = 6;
   localparam int SIGNED_BIT      = 5;
   localparam int SLEEP_BIT       = 4;
   localparam int NAP2_BIT        = 3;
   localparam int NAP1_BIT        = 0;
   localparam int CUR_HI          = 7;
   localparam int CUR_LO          = 5;
   localparam int TERM_BIT        = 4;
   localparam int OUT_OFF_BIT     = 3;
   localparam int LANE_HI         = 2;
   localparam int LANE_LO         = 0;
   // writable masks: unused bits read as zero
   localparam logic [7:0] POWER_FMT_MASK = 8'hF9;
   localparam logic [7:0] OUT_DRIVE_MASK = 8'hFF;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [2:0] CUR_RESERVED   = 3'h3;
   localparam logic [2:0] LANE_RES_A     = 3'h3;
   localparam logic [2:0] LANE_RES_B     = 3'h4;
endpackage : cfg_port_pkg

/* rtl/sync2.sv */
`timescale 1ns/1ns
// two flop synchroniser for an asynchronous pin
module sync2 (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // pin in, synchronised out
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;

   // reset value is high for all pins, the idle level of chip select
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= 1'b1;
         dout    <= 1'b1;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule : sync2

/* rtl/adc_serial_config_port.sv */
`timescale 1ns/1ns
// Contract
// - one sixteen bit word per access
// - chip select falls, sample sixteen rising edges
// - edges past sixteenth are ignored
// - chip select rising ends the word
// - rw flag, seven address, eight data
// - rw zero writes addressed register
// - rw one reads back, no update
// - data out is open drain
// - reset bit clears registers, sleeps briefly
// - reset bit self clears after write
// - bit seven disables duty stabilizer
// - bit six enables output scrambling
// - bit five selects two's complement
// - bits four three zero set power
// - bits seven to five select current
// - termination doubles driver current
// - bit three turns outputs off
// - scrambler xors lsb into other bits
module adc_serial_config_port
   import cfg_port_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // serial pins from the host
   input  wire logic       programming_mode_select,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       sdi,
   // open drain readback pin
   output logic            sdo_o,
   output logic            sdo_oe,
   // controls to the converter
   output logic            duty_stabilizer_disable,
   output logic            output_scramble_enable,
   output logic            signed_format_select,
   output logic            sleep_all,
   output logic            nap_ch1,
   output logic            nap_ch2,
   output logic [2:0]      driver_current_select,
   output logic            internal_termination_enable,
   output logic            driver_current_double,
   output logic            output_drivers_off,
   output logic [2:0]      lane_serialization_select,
   output logic            one_lane_mode,
   output logic            lane_code_reserved,
   output logic            current_code_reserved,
   // sample path scrambler (registered, one clock of latency)
   input  wire logic [13:0] sample_in,
   output logic [13:0]     sample_out
);

   // synchronised pins
   logic cs_s;
   logic sck_s;
   logic sdi_s;
   logic mode_s;

   sync2 u_sync_cs   (.clk(clk), .nrst(nrst), .din(cs_n), .dout(cs_s));
   sync2 u_sync_sck  (.clk(clk), .nrst(nrst), .din(sck), .dout(sck_s));
   sync2 u_sync_sdi  (.clk(clk), .nrst(nrst), .din(sdi), .dout(sdi_s));
   sync2 u_sync_mode (.clk(clk), .nrst(nrst), .din(programming_mode_select),
                      .dout(mode_s));

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE  = 2'b11
   } phase_t;

   typedef struct packed {
      phase_t      phase;
      logic        cs_d;
      logic        sck_d;
      logic        is_read;
      logic [4:0]  cnt;
      logic [15:0] shreg;
      logic [7:0]  rd_data;
      logic        sdo_low;
      logic [7:0]  pwr;
      logic [7:0]  drv;
      logic        sleep_pulse;
      logic [13:0] smp;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic serial_mode;
   logic [15:0] word;

   assign serial_mode = !mode_s;
   assign cs_fall  = cur_ff.cs_d & !cs_s;
   assign cs_rise  = !cur_ff.cs_d & cs_s;
   assign sck_rise = !cur_ff.sck_d & sck_s;
   assign sck_fall = cur_ff.sck_d & !sck_s;
   assign word     = cur_ff.shreg;

   // register read mux, unused bits forced low
   function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] p,
                                            input logic [7:0] d);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         POWER_FMT_ADDR: r = p & POWER_FMT_MASK;
         OUT_DRIVE_ADDR: r = d & OUT_DRIVE_MASK;
         default:        r = 8'h00; // reset register is write only
      endcase
      return r;
   endfunction : read_reg

   // next state: pin edges, shifting, commit
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.cs_d        = cs_s;
      nxt_cur.sck_d       = sck_s;
      nxt_cur.sleep_pulse = 1'b0;
      // scrambler runs every clock, one flop of latency
      nxt_cur.smp = sample_in;
      if (cur_ff.pwr[SCRAMBLE_BIT]) begin
         nxt_cur.smp = sample_in ^ {{13{sample_in[0]}}, 1'b0};
      end
      case (cur_ff.phase)
         ST_IDLE: begin
            nxt_cur.sdo_low = 1'b0;
            if (cs_fall && serial_mode) begin
               nxt_cur.phase = ST_SHIFT;
               nxt_cur.cnt   = 5'h00;
               nxt_cur.shreg = 16'h0000;
            end
         end
         ST_SHIFT: begin
            if (cs_rise) begin
               nxt_cur.phase   = ST_IDLE;
               nxt_cur.sdo_low = 1'b0;
            end else if (sck_rise) begin
               nxt_cur.shreg = {cur_ff.shreg[14:0], sdi_s};
               nxt_cur.cnt   = cur_ff.cnt + 5'h01;
               // first bit of the word is the read flag; keep it for the data half
               if (cur_ff.cnt == 5'h00) begin
                  nxt_cur.is_read = sdi_s;
               end
               if (cur_ff.cnt + 5'h01 == LAST_BIT) begin
                  nxt_cur.phase = ST_DONE;
               end
               // after the last address bit, latch readback data
               if (cur_ff.cnt + 5'h01 == READ_FROM) begin
                  nxt_cur.rd_data = read_reg({cur_ff.shreg[5:0], sdi_s},
                                             cur_ff.pwr, cur_ff.drv);
               end
            end else if (sck_fall && cur_ff.is_read && cur_ff.cnt >= READ_FROM) begin
               // host samples on rise, so present each bit on the fall
               nxt_cur.sdo_low = !cur_ff.rd_data[7];
               nxt_cur.rd_data = {cur_ff.rd_data[6:0], 1'b0};
            end
         end
         ST_DONE: begin
            // edges past the sixteenth are dropped here
            if (sck_fall && word[RW_POS]) begin
               nxt_cur.sdo_low = 1'b0;
            end
            if (cs_rise) begin
               nxt_cur.phase   = ST_IDLE;
               nxt_cur.sdo_low = 1'b0;
               if (!word[RW_POS]) begin
                  case (word[ADDR_HI:ADDR_LO])
                     SOFT_RESET_ADDR: begin
                        if (word[SOFT_RESET_BIT]) begin
                           nxt_cur.pwr         = REG_RESET;
                           nxt_cur.drv         = REG_RESET;
                           nxt_cur.sleep_pulse = 1'b1;
                        end
                     end
                     POWER_FMT_ADDR: nxt_cur.pwr = word[DATA_HI:DATA_LO] & POWER_FMT_MASK;
                     OUT_DRIVE_ADDR: nxt_cur.drv = word[DATA_HI:DATA_LO];
                     default: ;
                  endcase
               end
            end
         end
         default: nxt_cur.phase = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '{phase: ST_IDLE, cs_d: 1'b1, sck_d: 1'b1, is_read: 1'b0, cnt: 5'h00,
                     shreg: 16'h0000, rd_data: 8'h00, sdo_low: 1'b0,
                     pwr: REG_RESET, drv: REG_RESET, sleep_pulse: 1'b0,
                     smp: 14'h0000};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // outputs straight from the state flops
   assign sdo_o  = 1'b0;
   assign sdo_oe = cur_ff.sdo_low;
   assign duty_stabilizer_disable = cur_ff.pwr[DCS_OFF_BIT];
   assign output_scramble_enable  = cur_ff.pwr[SCRAMBLE_BIT];
   assign signed_format_select    = cur_ff.pwr[SIGNED_BIT];
   // software reset sleeps the chip for one cycle
   assign sleep_all = cur_ff.pwr[SLEEP_BIT] | cur_ff.sleep_pulse;
   assign nap_ch1   = cur_ff.pwr[NAP1_BIT] & !cur_ff.pwr[SLEEP_BIT];
   assign nap_ch2   = cur_ff.pwr[NAP2_BIT] & !cur_ff.pwr[SLEEP_BIT];
   assign driver_current_select       = cur_ff.drv[CUR_HI:CUR_LO];
   assign current_code_reserved       = cur_ff.drv[CUR_HI:CUR_LO] == CUR_RESERVED;
   assign internal_termination_enable = cur_ff.drv[TERM_BIT];
   assign driver_current_double       = cur_ff.drv[TERM_BIT];
   assign output_drivers_off          = cur_ff.drv[OUT_OFF_BIT];
   assign lane_serialization_select   = cur_ff.drv[LANE_HI:LANE_LO];
   assign one_lane_mode      = cur_ff.drv[LANE_HI] & (cur_ff.drv[1:0] != 2'b00);
   assign lane_code_reserved = (cur_ff.drv[LANE_HI:LANE_LO] == LANE_RES_A) |
                               (cur_ff.drv[LANE_HI:LANE_LO] == LANE_RES_B);
   assign sample_out = cur_ff.smp;

   // checks
   short_abort_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.phase == ST_SHIFT && cs_rise) |=> $stable(cur_ff.pwr) && $stable(cur_ff.drv))
      else $error("short word changed a register");
   done_stable_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.phase == ST_DONE && !cs_rise) |=> $stable(cur_ff.shreg))
      else $error("bit taken past sixteenth");
   count_limit_a: assert property (@(posedge clk) disable iff (!nrst)
      cur_ff.cnt <= LAST_BIT) else $error("bit count overran");
   write_commit_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.phase == ST_DONE && cs_rise && !word[RW_POS]
       && word[ADDR_HI:ADDR_LO] == POWER_FMT_ADDR)
      |=> cur_ff.pwr == ($past(word[DATA_HI:DATA_LO]) & POWER_FMT_MASK))
      else $error("write not stored");
   read_nochange_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.phase == ST_DONE && cs_rise && word[RW_POS])
      |=> $stable(cur_ff.pwr) && $stable(cur_ff.drv))
      else $error("read changed register");
   soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.phase == ST_DONE && cs_rise && !word[RW_POS]
       && word[ADDR_HI:ADDR_LO] == SOFT_RESET_ADDR && word[SOFT_RESET_BIT])
      |=> cur_ff.pwr == 8'h00 && cur_ff.drv == 8'h00 && sleep_all ##1 !cur_ff.sleep_pulse)
      else $error("soft reset misbehaved");
   sdo_idle_a: assert property (@(posedge clk) disable iff (!nrst)
      cur_ff.phase == ST_IDLE |=> !sdo_oe || cur_ff.phase != ST_IDLE)
      else $error("data out pulled while idle");
   unused_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.pwr & ~POWER_FMT_MASK) == 8'h00)
      else $error("unused bits set");
   scramble_out_a: assert property (@(posedge clk) disable iff (!nrst)
      cur_ff.pwr[SCRAMBLE_BIT] |=> sample_out[13:1] ==
         ($past(sample_in[13:1]) ^ {13{$past(sample_in[0])}}))
      else $error("scramble wrong");
   write_cov: cover property (@(posedge clk) cur_ff.phase == ST_DONE && cs_rise
                              && !word[RW_POS]);
   read_cov:  cover property (@(posedge clk) cur_ff.phase == ST_DONE && cs_rise
                              && word[RW_POS]);
   abort_cov: cover property (@(posedge clk) cur_ff.phase == ST_SHIFT && cs_rise);
endmodule : adc_serial_config_port

/* verif/cfg_host_model.sv */
`timescale 1ns/1ns
// host controller on the far side of the serial port
module cfg_host_model (
   // bench clock, only to line frames up
   input  wire logic clk,
   // open drain readback wire, pulled up on the board
   input  wire logic sdo,
   // serial pins toward the device
   output logic      cs_n,
   output logic      sck,
   output logic      sdi
);
   // serial clock stands still between frames
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      sdi  = 1'b0;
   end

   // one frame of nbits rising edges, msb first; edges past 16 carry noise
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
      logic [15:0] sh;
      sh = w;
      rd = 8'h00;
      @(negedge clk);
      #1 cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi = (i < 16) ? sh[15] : 1'($urandom_range(1));
         sh  = {sh[14:0], 1'b0};
         #62;
         if (i >= 8 && i < 16) begin
            rd = {rd[6:0], sdo};
         end
         sck = 1'b1;
         #63;
         sck = 1'b0;
      end
      #62 cs_n = 1'b1;
      sdi = ~sdi; // released line must not show the last bit
      #100;
   endtask : xfer
endmodule : cfg_host_model

/* verif/adc_serial_config_port_test.sv */
`timescale 1ns/1ns
module adc_serial_config_port_test
   import cfg_port_pkg::*;
;
   logic        clk;
   logic        nrst;
   logic        cs_n;
   logic        sck;
   logic        sdi;
   logic        sdo_o;
   logic        sdo_oe;
   wire         sdo;
   logic [17:0] ctl;
   logic [13:0] sample_in = 14'h0000;
   logic [13:0] sample_out;
   logic [7:0]  reg1;
   logic [7:0]  reg2;
   logic [7:0]  rd;
   logic        last_en = 1'b0;
   logic        chk_on = 1'b0;
   int          bad_count;
   int          num_checks;

   // board pull-up on the open drain line
   assign sdo = (sdo_oe && !sdo_o) ? 1'b0 : 1'b1;

   // mode select strapped low for serial use
   adc_serial_config_port u_adc_serial_config_port (
      .clk(clk), .nrst(nrst), .programming_mode_select(1'b0),
      .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .duty_stabilizer_disable(ctl[17]), .output_scramble_enable(ctl[16]),
      .signed_format_select(ctl[15]), .sleep_all(ctl[14]), .nap_ch1(ctl[13]),
      .nap_ch2(ctl[12]), .driver_current_select(ctl[11:9]),
      .internal_termination_enable(ctl[8]), .driver_current_double(ctl[7]),
      .output_drivers_off(ctl[6]), .lane_serialization_select(ctl[5:3]),
      .one_lane_mode(ctl[2]), .lane_code_reserved(ctl[1]),
      .current_code_reserved(ctl[0]), .sample_in(sample_in), .sample_out(sample_out));

   cfg_host_model u_cfg_host_model (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi));

   always #4 clk = ~clk;

   // decoded controls expected from the two register images
   function automatic logic [17:0] exp_ctl(input logic [7:0] a, input logic [7:0] b);
      return {a[7], a[6], a[5], a[4], a[0] & ~a[4], a[3] & ~a[4], b[7:5], b[4], b[4], b[3],
              b[2:0], b[2:0] >= 3'h5, b[2:0] == 3'h3 || b[2:0] == 3'h4, b[7:5] == 3'h3};
   endfunction : exp_ctl

   function automatic logic [13:0] scr(input logic [13:0] x, input logic en);
      return en ? {x[13:1] ^ {13{x[0]}}, x[0]} : x;
   endfunction : scr

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   // a write updates the bench image only when the word was whole
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
      logic [7:0] v;
      u_cfg_host_model.xfer({1'b0, a, d}, n, v);
      if (n >= 16) begin
         if (a == POWER_FMT_ADDR) reg1 = d & POWER_FMT_MASK;
         if (a == OUT_DRIVE_ADDR) reg2 = d;
         if (a == SOFT_RESET_ADDR && d[7]) begin
            reg1 = 8'h00;
            reg2 = 8'h00;
         end
      end
   endtask : wr

   // readback with noise on the data bits, then controls again
   task automatic verify();
      logic [7:0] v;
      check(32'(ctl), 32'(exp_ctl(reg1, reg2)));
      u_cfg_host_model.xfer({1'b1, POWER_FMT_ADDR, 8'($urandom)}, 16, v);
      check(32'(v), 32'(reg1));
      u_cfg_host_model.xfer({1'b1, OUT_DRIVE_ADDR, 8'($urandom)}, 16, v);
      check(32'(v), 32'(reg2));
      check(32'(ctl), 32'(exp_ctl(reg1, reg2)));
   endtask : verify

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // random samples; output is the last input, scrambled by the old enable
   always @(negedge clk) begin
      if (chk_on) check(32'(sample_out), 32'(scr(sample_in, last_en)));
      last_en   = ctl[16];
      sample_in = 14'($urandom);
   end

   // watchdog well past the expected run of about 100 us
   initial begin
      #500000;
      bad_count++;
      test_done();
   end

   // main sequence
   initial begin
      int n;
      logic [7:0] d;
      clk = 1'b0;
      nrst = 1'b0;
      reg1 = 8'h00;
      reg2 = 8'h00;
      bad_count = 0;
      num_checks = 0;
      void'($urandom(22856));
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      chk_on = 1'b1;
      check(32'({sdo_oe, ctl}), 32'h0);
      wr(SOFT_RESET_ADDR, 8'h80, 16);
      verify();
      // random words; some run long, some are cut short
      for (int i = 0; i < 10; i++) begin
         n = (i % 4 == 1) ? 20 : (i % 4 == 3) ? 11 : 16;
         d = 8'($urandom);
         // termination only with the three highest current codes
         if (d[4] && d[7:5] < 3'h5) d[4] = 1'b0;
         wr(7'($urandom_range(3)), d, n);
         verify();
      end
      u_cfg_host_model.xfer({1'b1, SOFT_RESET_ADDR, 8'hFF}, 16, rd);
      check(32'(rd), 32'h0);
      wr(7'h7F, 8'hFF, 16);
      u_cfg_host_model.xfer({1'b1, 7'h7F, 8'h00}, 16, rd);
      check(32'(rd), 32'h0);
      wr(POWER_FMT_ADDR, 8'hFF, 16);
      wr(OUT_DRIVE_ADDR, 8'hFF, 16);
      verify();
      wr(SOFT_RESET_ADDR, 8'hFF, 16);
      verify();
      // sleep was just lifted; let the channels settle before going on
      repeat (100) @(negedge clk);
      // a later write must stick once the reset bit has cleared itself
      wr(OUT_DRIVE_ADDR, 8'hB3, 16);
      wr(POWER_FMT_ADDR, 8'h49, 16);
      verify();
      test_done();
   end
endmodule : adc_serial_config_port_test
